// >>> verilog/uart_lin.v
// Serial port with flags, interrupt requests and clock selection.
//
// Summary of operation
// - Framed receive stores word at first stop bit.
// - Unframed sync receive stores after last data bit.
// - Receive request when any receive flag and enable.
// - Receive buffer invalid after a framing or parity error.
// - Empty flag sets when word enters shifter.
// - Transmit request while empty flag and enable.
// - Empty flag read-only, cleared by buffer write.
// - Empty flag resets to one.
// - No parity in modes 1 and 3 or unframed sync.
// - Separate transmit and receive reload counters.
// - Fifteen-bit reload split over two registers.
// - Both selects zero: counters use machine clock.
// - External select alone: counters divide external clock.
// - Both selects one: clock pin drives sync mode directly; async counters still divide it.
// - Overrun when word arrives while buffer full.
// - Framing error on bad stop; parity error on parity mismatch.
// - Reading receive buffer clears full flag.
// - Writing clear bit clears all error flags.
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "uart_lin_defines.vh"

module uart_lin (
    input wire clk_i, // Machine clock, 10 MHz.
    input wire rst_i, // Synchronous reset, active high.
    input wire wb_cyc_i, // Wishbone cycle.
    input wire wb_stb_i, // Wishbone strobe.
    input wire wb_we_i, // Wishbone write enable.
    input wire [4:0] wb_adr_i, // Wishbone byte address.
    input wire [3:0] wb_sel_i, // Wishbone byte lanes.
    input wire [31:0] wb_dat_i, // Wishbone write data.
    output reg [31:0] wb_dat_o, // Wishbone read data.
    output reg wb_ack_o, // Wishbone acknowledge.
    input wire sin_i, // Serial data in.
    output reg sout_o, // Serial data out.
    input wire sck_i, // Serial clock pin input.
    output reg sck_o, // Serial clock pin output.
    output reg sck_oe_n_o, // Clock pin drive, low drives.
    output reg rx_irq_o, // Receive interrupt request.
    output reg tx_irq_o // Transmit interrupt request.
);

    ////////////////////////////////////////////////////////////////////
    // Registers and flags.

    reg [7:0] mode_r; // serial_mode_reg.
    reg [2:1] ctrl_r; // serial_control_reg enables.
    reg [6:0] baud_hi_r; // baud_reload_high.
    reg [7:0] baud_lo_r; // baud_reload_low.
    reg [7:0] rxbuf_r; // rx_buffer_reg.
    reg [7:0] txbuf_r; // tx_buffer_reg.
    reg rx_full_r; // rx_full_flag.
    reg ovr_r; // overrun_err_flag.
    reg frm_r; // framing_err_flag.
    reg perr_r; // parity_err_flag.
    reg tx_empty_r; // tx_empty_flag.
    reg rx_full_nxt;
    reg ovr_nxt;
    reg frm_nxt;
    reg perr_nxt;
    reg tx_empty_nxt;
    reg sck_d_r; // Previous clock pin level.
    reg [3:0] tx_cnt_r; // Bits left in the transmit frame.
    reg [9:0] tx_shift_r; // Remaining transmit bits.
    reg tx_active_r; // A frame is on the line.

    wire [1:0] opm = mode_r[`MODE_OP_HI:`MODE_OP_LO];
    wire ext_clock_sel = mode_r[`MODE_EXT];
    wire one_to_one_clock_sel = mode_r[`MODE_ONE];
    wire start_stop_framing_sel = mode_r[`MODE_FRM];
    wire master_slave_sel = mode_r[`MODE_SLV];
    wire rx_irq_enable = ctrl_r[`CTRL_RXI];
    wire tx_irq_enable = ctrl_r[`CTRL_TXI];
    wire [14:0] reload = {baud_hi_r, baud_lo_r};

    ////////////////////////////////////////////////////////////////////
    // Bus decode. Every access is answered one cycle after it is taken,
    // unmapped ones included, so a stray address never hangs the bus.

    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire rd = req && !wb_we_i;
    wire [4:0] adr = {wb_adr_i[4:2], 2'b00};
    wire wr_mode = wr && adr == `OFS_MODE;
    wire wr_ctrl = wr && adr == `OFS_CTRL;
    wire wr_tx = wr && adr == `OFS_TXBUF;
    wire wr_bhi = wr && adr == `OFS_BAUD_HI;
    wire wr_blo = wr && adr == `OFS_BAUD_LO;
    wire rd_rx = rd && adr == `OFS_RXBUF;
    wire err_clr = wr_ctrl && wb_dat_i[`CTRL_CLR];

    ////////////////////////////////////////////////////////////////////
    // Frame options shared by both directions.

    wire sync = opm == `OPM_SYNC;
    wire framed = !sync || start_stop_framing_sel;
    // Parity is off in mode 1, in mode 3 and in unframed sync.
    wire par_use = mode_r[`MODE_PEN] &&
        (opm == `OPM_ASYNC || (sync && start_stop_framing_sel));

    // Even or odd parity bit over a data word.
    function par_bit;
        input [7:0] d;
        input odd;
        begin
            par_bit = (^d) ^ odd;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Clock selection. The pin is sampled on the machine clock, so an
    // external clock faster than half the machine clock is lost.

    wire ext_rise = sck_i && !sck_d_r;
    wire ext_fall = !sck_i && sck_d_r;
    wire pin_mode = ext_clock_sel && one_to_one_clock_sel;
    // Counters divide the machine clock or the external clock.
    wire src_en = ext_clock_sel ? ext_rise : 1'b1;
    wire master = sync && !master_slave_sel && !pin_mode;
    wire tx_tick;
    wire rx_tick;
    wire rx_restart;
    wire baud_wr = wr_bhi || wr_blo;

    // One counter paces transmission, the other reception.
    baud_reload #(.W(15)) u_tx_reload (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(src_en),
        .restart_i(baud_wr),
        .half_i(1'b0),
        .reload_i(reload),
        .tick_o(tx_tick)
    );

    baud_reload #(.W(15)) u_rx_reload (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(src_en),
        .restart_i(baud_wr || rx_restart),
        .half_i(rx_restart),
        .reload_i(reload),
        .tick_o(rx_tick)
    );

    // The internal sync clock rests high and only runs with work queued.
    wire int_rise = master && tx_tick && !sck_o;
    wire int_fall = master && tx_tick && sck_o &&
        (tx_active_r || !tx_empty_r);
    // One-to-one mode takes the pin edges as the serial clock.
    wire sync_rise = pin_mode ? ext_rise : int_rise;
    wire sync_fall = pin_mode ? ext_fall : int_fall;
    wire rx_bit = sync ? sync_rise : rx_tick;
    wire tx_bit = sync ? sync_fall : tx_tick;

    ////////////////////////////////////////////////////////////////////
    // Receiver.

    wire rx_done;
    wire [7:0] rx_data;
    wire rx_fe;
    wire rx_perr;

    rx_frame u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sync_i(sync),
        .framed_i(framed),
        .par_use_i(par_use),
        .par_odd_i(mode_r[`MODE_PODD]),
        .sin_i(sin_i),
        .bit_i(rx_bit),
        .restart_o(rx_restart),
        .done_o(rx_done),
        .data_o(rx_data),
        .fe_o(rx_fe),
        .perr_o(rx_perr)
    );

    ////////////////////////////////////////////////////////////////////
    // Transmit start. A load waits for the next bit strobe when software is writing
    // the buffer, so a fresh word is never lost to the flag set.

    wire tx_load = tx_bit && !tx_empty_r && !wr_tx &&
        (!tx_active_r || tx_cnt_r == 4'h0);

    ////////////////////////////////////////////////////////////////////
    // Flag next values. Hardware sets win over software clears.
    always @* begin
        rx_full_nxt = rx_full_r;
        ovr_nxt = ovr_r;
        frm_nxt = frm_r;
        perr_nxt = perr_r;
        tx_empty_nxt = tx_empty_r;
        if (rd_rx) begin
            rx_full_nxt = 1'b0;
        end
        if (err_clr) begin
            ovr_nxt = 1'b0;
            frm_nxt = 1'b0;
            perr_nxt = 1'b0;
        end
        // Flags change in the cycle the buffer is written.
        if (rx_done) begin
            if (rx_full_r) begin
                ovr_nxt = 1'b1;
            end
            if (rx_fe) begin
                frm_nxt = 1'b1;
            end
            if (rx_perr) begin
                perr_nxt = 1'b1;
            end
            // A word with an error is not reported as complete.
            if (!rx_fe && !rx_perr) begin
                rx_full_nxt = 1'b1;
            end
        end
        if (wr_tx) begin
            tx_empty_nxt = 1'b0;
        end
        if (tx_load) begin
            tx_empty_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register file, flags and interrupt requests.
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= `MODE_RST;
            ctrl_r <= `CTRL_RST;
            {baud_hi_r, baud_lo_r} <= `BAUD_RST;
            rxbuf_r <= 8'h00;
            txbuf_r <= 8'h00;
            rx_full_r <= 1'b0;
            ovr_r <= 1'b0;
            frm_r <= 1'b0;
            perr_r <= 1'b0;
            tx_empty_r <= 1'b1;
            rx_irq_o <= 1'b0;
            tx_irq_o <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_r <= wb_dat_i[7:0];
            end
            if (wr_ctrl) begin
                ctrl_r <= wb_dat_i[2:1];
            end
            if (wr_bhi) begin
                baud_hi_r <= wb_dat_i[6:0];
            end
            if (wr_blo) begin
                baud_lo_r <= wb_dat_i[7:0];
            end
            if (wr_tx) begin
                txbuf_r <= wb_dat_i[7:0];
            end
            // Words with errors are still stored; software must
            // discard them when an error flag is up.
            if (rx_done) begin
                rxbuf_r <= rx_data;
            end
            rx_full_r <= rx_full_nxt;
            ovr_r <= ovr_nxt;
            frm_r <= frm_nxt;
            perr_r <= perr_nxt;
            tx_empty_r <= tx_empty_nxt;
            // Requests are levels and follow the flags.
            rx_irq_o <= rx_irq_enable &&
                (rx_full_r || ovr_r || frm_r || perr_r);
            tx_irq_o <= tx_irq_enable && tx_empty_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit shifter. The first bit goes out on the load strobe and
    // each later strobe moves one bit; a new word may follow directly.
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_active_r <= 1'b0;
            tx_cnt_r <= 4'h0;
            tx_shift_r <= 10'h000;
            sout_o <= 1'b1;
        end else if (tx_load) begin
            tx_active_r <= 1'b1;
            if (!framed) begin
                sout_o <= txbuf_r[0];
                tx_shift_r <= {3'h0, txbuf_r[7:1]};
                tx_cnt_r <= `LEN_DATA - 4'h1;
            end else if (par_use) begin
                sout_o <= 1'b0;
                tx_shift_r <= {1'b1,
                    par_bit(txbuf_r, mode_r[`MODE_PODD]), txbuf_r};
                tx_cnt_r <= `LEN_FRAME_PAR - 4'h1;
            end else begin
                sout_o <= 1'b0;
                tx_shift_r <= {2'b01, txbuf_r};
                tx_cnt_r <= `LEN_FRAME - 4'h1;
            end
        end else if (tx_bit && tx_active_r) begin
            if (tx_cnt_r == 4'h0) begin
                tx_active_r <= 1'b0;
                sout_o <= 1'b1;
            end else begin
                sout_o <= tx_shift_r[0];
                tx_shift_r <= {1'b0, tx_shift_r[9:1]};
                tx_cnt_r <= tx_cnt_r - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock pin: driven only as sync master, resting high.
    always @(posedge clk_i) begin
        if (rst_i) begin
            sck_d_r <= 1'b0;
            sck_o <= 1'b1;
            sck_oe_n_o <= 1'b1;
        end else begin
            sck_d_r <= sck_i;
            sck_oe_n_o <= !master;
            if (!master) begin
                sck_o <= 1'b1;
            end else if (int_rise || int_fall) begin
                sck_o <= !sck_o;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wishbone answer and read data.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h00000000;
            if (rd) begin
                case (adr)
                    `OFS_MODE: wb_dat_o[7:0] <= mode_r;
                    `OFS_CTRL: wb_dat_o[2:0] <= {ctrl_r, 1'b0};
                    `OFS_STAT: wb_dat_o[4:0] <= {tx_empty_r, perr_r,
                        frm_r, ovr_r, rx_full_r};
                    `OFS_RXBUF: wb_dat_o[7:0] <= rxbuf_r;
                    `OFS_TXBUF: wb_dat_o[7:0] <= txbuf_r;
                    `OFS_BAUD_HI: wb_dat_o[6:0] <= baud_hi_r;
                    `OFS_BAUD_LO: wb_dat_o[7:0] <= baud_lo_r;
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // uart_lin

// >>> verilog/uart_lin_defines.vh
// Register offsets, field positions, reset values and encodings.
`ifndef UART_LIN_DEFINES_VH
`define UART_LIN_DEFINES_VH

// Byte offsets of the register words on the Wishbone bus.
`define OFS_MODE 5'h00
`define OFS_CTRL 5'h04
`define OFS_STAT 5'h08
`define OFS_RXBUF 5'h0C
`define OFS_TXBUF 5'h10
`define OFS_BAUD_HI 5'h14
`define OFS_BAUD_LO 5'h18

// Field positions in serial_mode_reg.
`define MODE_OP_LO 0
`define MODE_OP_HI 1
`define MODE_EXT 2
`define MODE_ONE 3
`define MODE_FRM 4
`define MODE_SLV 5
`define MODE_PEN 6
`define MODE_PODD 7

// Field positions in serial_control_reg.
`define CTRL_CLR 0
`define CTRL_RXI 1
`define CTRL_TXI 2

// Field positions in serial_status_reg.
`define STAT_FULL 0
`define STAT_OVR 1
`define STAT_FRM 2
`define STAT_PAR 3
`define STAT_TEMPTY 4

// Operating mode encodings.
`define OPM_ASYNC 2'h0
`define OPM_MULTI 2'h1
`define OPM_SYNC 2'h2
`define OPM_LIN 2'h3

// Reset values.
`define MODE_RST 8'h00
`define CTRL_RST 2'h0
`define BAUD_RST 15'h0000

// Serial frame lengths in bits.
`define LEN_DATA 4'h8
`define LEN_FRAME 4'hA
`define LEN_FRAME_PAR 4'hB

`endif

// >>> verilog/baud_reload.v
// Fifteen-bit reload counter that yields a one-cycle bit tick.
`timescale 1ns/100ps

module baud_reload #(
    parameter W = 15
) (
    input wire clk_i, // Machine clock.
    input wire rst_i, // Synchronous reset, active high.
    input wire en_i, // Source clock enable pulse.
    input wire restart_i, // Reload the counter now.
    input wire half_i, // Restart at half period.
    input wire [W-1:0] reload_i, // Reload value.
    output reg tick_o // One pulse per reload period.
);

    reg [W-1:0] count_r; // Down counter.

    ////////////////////////////////////////////////////////////////////
    // A reload value of zero stops the counter, so the smallest useful
    // value is one. A half restart lets the receiver sample mid-bit.
    always @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= {W{1'b0}};
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (restart_i) begin
                count_r <= half_i ? (reload_i >> 1) : reload_i;
            end else if (en_i && reload_i != {W{1'b0}}) begin
                if (count_r == {W{1'b0}}) begin
                    tick_o <= 1'b1;
                    count_r <= reload_i;
                end else begin
                    count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // baud_reload

// >>> verilog/rx_frame.v
// Receive shifter: frames serial bits into a word and checks them.
`timescale 1ns/100ps
`include "uart_lin_defines.vh"

module rx_frame (
    input wire clk_i, // Machine clock.
    input wire rst_i, // Synchronous reset, active high.
    input wire sync_i, // Synchronous mode is selected.
    input wire framed_i, // Start and stop bits are used.
    input wire par_use_i, // A parity bit follows the data.
    input wire par_odd_i, // Odd parity when set.
    input wire sin_i, // Serial data in.
    input wire bit_i, // Bit sampling strobe.
    output reg restart_o, // Start edge seen, realign counter.
    output reg done_o, // Word complete, one cycle.
    output reg [7:0] data_o, // Received word.
    output reg fe_o, // Stop bit was low.
    output reg perr_o // Parity mismatch.
);

    localparam S_IDLE = 3'h0;
    localparam S_START = 3'h1;
    localparam S_DATA = 3'h2;
    localparam S_PAR = 3'h3;
    localparam S_STOP = 3'h4;

    reg [2:0] state_r; // Frame state.
    reg [2:0] cnt_r; // Data bit index.
    reg perr_r; // Parity result held until the stop bit.

    ////////////////////////////////////////////////////////////////////
    // Data arrives LSB first and is shifted in from the top.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            cnt_r <= 3'h0;
            perr_r <= 1'b0;
            restart_o <= 1'b0;
            done_o <= 1'b0;
            data_o <= 8'h00;
            fe_o <= 1'b0;
            perr_o <= 1'b0;
        end else begin
            restart_o <= 1'b0;
            done_o <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    perr_r <= 1'b0;
                    cnt_r <= 3'h0;
                    if (!sync_i) begin
                        // Falling edge of the start bit realigns timing.
                        if (!sin_i) begin
                            restart_o <= 1'b1;
                            state_r <= S_START;
                        end
                    end else if (bit_i) begin
                        if (framed_i) begin
                            if (!sin_i) begin
                                state_r <= S_DATA;
                            end
                        end else begin
                            // Unframed words begin on the first clock.
                            data_o <= {sin_i, data_o[7:1]};
                            cnt_r <= 3'h1;
                            state_r <= S_DATA;
                        end
                    end
                end
                S_START: begin
                    // Skip the stale tick of the realign cycle; high is a glitch.
                    if (bit_i && !restart_o) begin
                        state_r <= sin_i ? S_IDLE : S_DATA;
                    end
                end
                S_DATA: begin
                    if (bit_i) begin
                        data_o <= {sin_i, data_o[7:1]};
                        cnt_r <= cnt_r + 3'h1;
                        if (cnt_r == 3'h7) begin
                            if (!framed_i) begin
                                done_o <= 1'b1;
                                fe_o <= 1'b0;
                                perr_o <= 1'b0;
                                state_r <= S_IDLE;
                            end else begin
                                state_r <= par_use_i ? S_PAR : S_STOP;
                            end
                        end
                    end
                end
                S_PAR: begin
                    if (bit_i) begin
                        perr_r <= (^data_o) ^ sin_i ^ par_odd_i;
                        state_r <= S_STOP;
                    end
                end
                S_STOP: begin
                    // The word completes on the first stop bit.
                    if (bit_i) begin
                        done_o <= 1'b1;
                        fe_o <= !sin_i;
                        perr_o <= perr_r;
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

endmodule // rx_frame

// >>> dv/uart_lin_sva.sv
// Port-level checker for the serial port: bus timing and requests.
`timescale 1ns/100ps
`include "uart_lin_defines.vh"

module uart_lin_sva (
    input wire clk_i, // Machine clock.
    input wire rst_i, // Synchronous reset, active high.
    input wire wb_cyc_i, // Bus cycle.
    input wire wb_stb_i, // Bus strobe.
    input wire wb_we_i, // Bus write enable.
    input wire [4:0] wb_adr_i, // Bus byte address.
    input wire [3:0] wb_sel_i, // Bus byte lanes.
    input wire [31:0] wb_dat_o, // Read data.
    input wire wb_ack_o, // Acknowledge.
    input wire sout_o, // Serial data out.
    input wire sck_oe_n_o, // Clock pin drive, low drives.
    input wire rx_irq_o, // Receive request.
    input wire tx_irq_o // Transmit request.
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);

// A request still waiting for its answer.
wire pend = wb_cyc_i && wb_stb_i && !wb_ack_o;
// A write of the transmit buffer that carries its low byte.
wire tx_wr = pend && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_TXBUF;

////////////////////////////////////////////////////////////////////////
// Bus answer: one cycle late, one cycle wide, data only with it.
AST_ACK_ANS: assert property (pend |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge wider than one cycle");
AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(pend))
    else $error("acknowledge without a request");
AST_DAT_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside acknowledge");
// Reset must leave the line idle and both requests low.
AST_RST_IDLE: assert property (disable iff (1'b0) rst_i |=> sout_o &&
    sck_oe_n_o && !wb_ack_o && !rx_irq_o && !tx_irq_o)
    else $error("outputs not idle after reset");

////////////////////////////////////////////////////////////////////////
// Requests are levels: they only drop after software acted on the bus.
AST_TX_CLR: assert property (tx_wr |-> ##[1:2] !tx_irq_o)
    else $error("transmit request kept after buffer write");
AST_RX_HOLD: assert property ($fell(rx_irq_o) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("receive request dropped on its own");
AST_TX_HOLD: assert property ($fell(tx_irq_o) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("transmit request dropped on its own");

COV_RX: cover property ($rose(rx_irq_o));
COV_TX: cover property ($rose(tx_irq_o));
COV_FRAME: cover property ($fell(sout_o));
endmodule // uart_lin_sva

bind uart_lin uart_lin_sva chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sout_o(sout_o), .sck_oe_n_o(sck_oe_n_o),
    .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));

// >>> dv/serial_node.sv
// Remote serial node: sends frames to the block and decodes its frames.
`timescale 1ns/100ps

module serial_node (
    input wire clk_i, // Machine clock, used as the bit timer.
    input wire line_i, // Serial data from the block.
    output logic line_o // Serial data to the block.
);
int per = 16; // Bit length in clock cycles, set by the bench.
int rx_cnt = 0; // Words decoded.
int rx_bad = 0; // Words whose stop slot was low.
logic [7:0] rx_data = 8'h00; // Last word decoded.
initial line_o = 1'b1; // An idle line rests high.

// Holds one bit on the line for a full bit time.
task bit_out(input logic b);
    line_o <= b;
    repeat (per) @(posedge clk_i);
endtask

// Parity and stop level are arguments so that faults can be injected.
task send(input logic [7:0] d, input logic [1:0] par, input logic stp);
    @(posedge clk_i);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (par[1]) bit_out(par[0]);
    bit_out(stp);
    bit_out(1'b1); // Idle gap lets the block finish the word.
endtask

////////////////////////////////////////////////////////////////////////
// Samples each bit at its centre, least significant bit first.
always @(negedge line_i) begin
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
        repeat (per) @(posedge clk_i);
        rx_data[i] = line_i;
    end
    repeat (per) @(posedge clk_i);
    if (line_i !== 1'b1) rx_bad++; // A parity bit here would show as low.
    rx_cnt++;
end
endmodule // serial_node

// >>> dv/test_uart_lin.sv
// Self-checking bench: register access, receive flags, transmit path.
`timescale 1ns/100ps
`include "uart_lin_defines.vh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
    mismatches++; $display("[ERR] %s exp %h got %h", nm, e, s); end end

module test_uart_lin;
logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sck = 0; // Drives.
logic [4:0] adr = 5'h00; // Bus address.
logic [31:0] wdat = 32'h0, rd; // Write data and last read data.
wire [31:0] rdat; // Read data from the block.
wire ack, sout, sin, sck_o, oe_n, rx_irq, tx_irq; // Block outputs, and sin from the node.
int mismatches = 0, checks_done = 0, n, k;
typedef struct {logic [7:0] mode; int per; logic [7:0] d;
    logic [1:0] par; logic stp; logic [7:0] st;} row_t;
// Mode, bit time, word, parity use/value, stop, expected status.
row_t rows[7] = '{'{8'h00, 16, 8'hA5, 2'b00, 1'b1, 8'h11},
    '{8'h40, 16, 8'h3C, 2'b10, 1'b1, 8'h11},
    '{8'hC0, 16, 8'h3C, 2'b10, 1'b1, 8'h18},
    '{8'h00, 16, 8'h5A, 2'b00, 1'b0, 8'h14},
    '{8'h43, 16, 8'h96, 2'b00, 1'b1, 8'h11},
    '{8'h04, 32, 8'h81, 2'b00, 1'b1, 8'h11},
    '{8'h3E, 2, 8'hC3, 2'b00, 1'b1, 8'h11}};
logic [7:0] tx_words[2] = '{8'h0F, 8'h55}; // Even weight: parity 0.

always #50 clk_i = ~clk_i;
// External clock runs at half the machine clock.
always @(posedge clk_i) sck <= ~sck;

uart_lin DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sin_i(sin),
    .sout_o(sout), .sck_i(sck), .sck_o(sck_o), .sck_oe_n_o(oe_n),
    .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
serial_node node (.clk_i(clk_i), .line_i(sout), .line_o(sin));

////////////////////////////////////////////////////////////////////////
// Prints the counts and the verdict, then stops.
task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask

// A wait that used up its bound ends the run.
task lim(input int c);
    if (c >= 400) begin
        mismatches++;
        $display("[ERR] wait exp done got timeout");
        results();
    end
endtask

// One classic bus cycle; the request holds until ack is sampled.
task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 400 && ack !== 1'b1; n++) @(posedge clk_i);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    lim(n);
endtask

////////////////////////////////////////////////////////////////////////
initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `OFS_STAT, 0);
    `CHK("status", 8'h10, rd[7:0])
    `CHK("tx_irq", 1'b0, tx_irq)
    wb(1, `OFS_BAUD_HI, 0);
    wb(1, `OFS_BAUD_LO, 15);
    wb(1, `OFS_CTRL, 32'h6);
    repeat (3) @(posedge clk_i);
    `CHK("tx_irq", 1'b1, tx_irq)
    foreach (rows[i]) begin
        wb(1, `OFS_MODE, rows[i].mode);
        node.per = rows[i].per;
        node.send(rows[i].d, rows[i].par, rows[i].stp);
        for (n = 0; n < 400 && rx_irq !== 1'b1; n++) @(posedge clk_i);
        lim(n);
        wb(0, `OFS_STAT, 0);
        `CHK("status", rows[i].st, rd[7:0])
        wb(0, `OFS_RXBUF, 0);
        if (rows[i].st[0]) `CHK("rx_buf", rows[i].d, rd[7:0])
        wb(1, `OFS_CTRL, 32'h7);
        wb(0, `OFS_STAT, 0);
        `CHK("cleared", 8'h10, rd[7:0])
        `CHK("rx_irq", 1'b0, rx_irq)
        `CHK("oe_n", 1'b1, oe_n)
        `CHK("sck", 1'b1, sck_o)
    end
    // Two words with no read between them.
    wb(1, `OFS_MODE, 0);
    node.per = 16;
    node.send(8'hA1, 2'b00, 1'b1);
    node.send(8'hB2, 2'b00, 1'b1);
    wb(0, `OFS_STAT, 0);
    `CHK("overrun", 8'h13, rd[7:0])
    `CHK("rx_irq", 1'b1, rx_irq)
    wb(0, `OFS_RXBUF, 0);
    wb(1, `OFS_CTRL, 32'h7);
    // Transmit in the link mode with parity asked for.
    wb(1, `OFS_MODE, 32'h43);
    wb(1, `OFS_STAT, 0);
    wb(0, `OFS_STAT, 0);
    `CHK("status_ro", 8'h10, rd[7:0])
    for (k = 0; k < 2; k++) begin
        wb(1, `OFS_TXBUF, tx_words[k]);
        @(posedge clk_i);
        `CHK("tx_irq", 1'b0, tx_irq)
        for (n = 0; n < 400 && tx_irq !== 1'b1; n++) @(posedge clk_i);
        lim(n);
    end
    for (n = 0; n < 400 && node.rx_cnt < 2; n++) @(posedge clk_i);
    lim(n);
    `CHK("tx_word", 8'h55, node.rx_data)
    `CHK("no_parity", 0, node.rx_bad)
    wb(0, `OFS_STAT, 0);
    `CHK("status", 8'h10, rd[7:0])
    results();
end
endmodule // test_uart_lin
